// ---- inc/ipcd_pkg.sv ----
/*
  ipcd_pkg: constants, register map and helper functions for the input
  port change detector (six input pins, four with change detection).
  Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
// How it works
// R1 - reading the pin state register returns live pin levels, whatever function
// R2 - a pin state bit reads 1 for a high pin, 0 for a low pin
// R3 - pin 0 drives channel A clear-to-send when mode two A bit 4 set
// R4 - pin 1 drives channel B clear-to-send when mode two B bit 4 set
// R5 - pin 2 clocks the counter/timer when aux control bits 6:4 are 000
// R6 - pin 2 clocks channel B receiver when its clock select 7:4 is 1110/1111
// R7 - pin 3 clocks channel A transmitter when its clock select 3:0 is 1110/1111
// R8 - pin 4 clocks channel A receiver when its clock select 7:4 is 1110/1111
// R9 - pin 5 clocks channel B transmitter when its clock select 3:0 is 1110/1111
// R10 - only pins 0 to 3 have change detection, sampled at 38.4 kHz
// R11 - a change held two sample periods always flags; one period may flag
// R12 - change status: flags for pins 3..0 in bits 7:4, levels in 3:0
// R13 - reading change status clears bits 7:4, levels are untouched
// R14 - aux control bits 3:0 enable each pin's flag onto the interrupt
// R15 - interrupt only while mask bit 7 set and an enabled flag is set
// R16 - aux bit 7 selects bit rate set 1 or 2; bits 6:4 timer mode
// R17 - 28-pin variant has only pin 2: timer clock and channel B rx clock
// R18 - flag when two consecutive samples differ from accepted level, then accept
package ipcd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned SAMPLE_HZ   = 38_400;
  localparam int unsigned TICK_CYCLES = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned TICK_W      = 12;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [11:0] OFS_PIN_STATE = 12'h000;
  localparam logic [11:0] OFS_CHANGE    = 12'h004;
  localparam logic [11:0] OFS_AUX       = 12'h008;
  localparam logic [11:0] OFS_IMASK     = 12'h00C;
  localparam logic [11:0] OFS_MODE2_A   = 12'h010;
  localparam logic [11:0] OFS_MODE2_B   = 12'h014;
  localparam logic [11:0] OFS_CLKSEL_A  = 12'h018;
  localparam logic [11:0] OFS_CLKSEL_B  = 12'h01C;

  ////////////////////////////////////////////////////////////////////////////
  // field positions, codes and reset values
  localparam int unsigned MODE2_CTS_BIT    = 4;
  localparam int unsigned AUX_BRG_BIT      = 7;
  localparam int unsigned IMASK_CHANGE_BIT = 7;
  localparam logic [2:0]  CT_EXT_CODE      = 3'h0;
  localparam logic [3:0]  CLKSEL_EXT16     = 4'hE;
  localparam logic [3:0]  CLKSEL_EXT1      = 4'hF;
  localparam logic [7:0]  REG_RESET        = 8'h00;
  localparam logic [5:0]  PIN28_MASK       = 6'h04;

  // a clock select nibble that picks the external pin clock
  function automatic logic ext_clock_sel(input logic [3:0] nib);
    return (nib == CLKSEL_EXT16) || (nib == CLKSEL_EXT1);
  endfunction

  // register offsets that answer on the bus
  function automatic logic addr_mapped(input logic [11:0] a);
    return (a == OFS_PIN_STATE) || (a == OFS_CHANGE) || (a == OFS_AUX)
        || (a == OFS_IMASK) || (a == OFS_MODE2_A) || (a == OFS_MODE2_B)
        || (a == OFS_CLKSEL_A) || (a == OFS_CLKSEL_B);
  endfunction

endpackage

// ---- inc/ipcd_if.sv ----
/*
  ipcd_if: carries the sample tick and pin levels to the change detector
  and its change pulses back. Both ends share one clock.
*/
`timescale 1ns/1ns
interface ipcd_if;
  logic       tick;
  logic [3:0] level;
  logic [3:0] change;

  modport src (output tick, output level, input change);
  modport det (input tick, input level, output change);
endinterface

// ---- src/ipcd_detect.sv ----
/*
  ipcd_detect: change-of-state detector for four input pins, evaluated
  on each sample tick. Assumes levels are synchronous to i_mclk.
*/
`timescale 1ns/1ns
module ipcd_detect
  import ipcd_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_reset_n,
  ipcd_if.det       bus
);

  typedef struct packed {
    logic [3:0] accepted;
    logic [3:0] prev;
    logic [3:0] change;
    logic       primed;
  } ipcd_det_type;

  ipcd_det_type st_r;
  ipcd_det_type st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // two-sample filter per pin
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.change = 4'h0;
    if (bus.tick)
    begin
      st_nxt.prev = bus.level;
      if (!st_r.primed)
      begin
        // first tick after reset takes the levels as they stand
        st_nxt.accepted = bus.level;
        st_nxt.primed   = 1'b1;
      end
      else
      begin
        for (int i = 0; i < 4; i++)
        begin
          if ((bus.level[i] != st_r.accepted[i]) && (st_r.prev[i] != st_r.accepted[i]))
          begin
            st_nxt.change[i]   = 1'b1; // R18 R11
            st_nxt.accepted[i] = bus.level[i];
          end
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign bus.change = st_r.change;

endmodule

// ---- src/ipcd_top.sv ----
/*
  ipcd_top: input port of a dual serial controller. Holds the pin state
  and change status registers, the configuration that routes pins to
  their alternate functions, and the change interrupt.
  Assumes an APB master on i_mclk and pins synchronous to i_mclk.
*/
`timescale 1ns/1ns
module ipcd_top
  import ipcd_pkg::*;
#(
  parameter bit          PIN28      = 1'b0,
  parameter int unsigned TICK_COUNT = TICK_CYCLES
)
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic [5:0]  i_input_pin,
  output logic             o_irq,
  output logic             o_clear_to_send_chan_a_n,
  output logic             o_clear_to_send_chan_b_n,
  output logic             o_timer_ext_clock_in,
  output logic             o_rx_clock_in_chan_b,
  output logic             o_tx_clock_in_chan_a,
  output logic             o_rx_clock_in_chan_a,
  output logic             o_tx_clock_in_chan_b,
  output logic [2:0]       o_timer_mode,
  output logic             o_brg_set2,
  output logic [3:0]       o_ext_clock_active
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [7:0]        auxiliary_control;
    logic [7:0]        interrupt_mask;
    logic [7:0]        mode_two_chan_a;
    logic [7:0]        mode_two_chan_b;
    logic [7:0]        clock_select_chan_a;
    logic [7:0]        clock_select_chan_b;
    logic [3:0]        change_flags;
    logic [TICK_W-1:0] tick_cnt;
    logic              tick;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    logic              irq;
    logic              cts_a_n;
    logic              cts_b_n;
    logic              timer_clk;
    logic              rxc_b;
    logic              txc_a;
    logic              rxc_a;
    logic              txc_b;
    logic [3:0]        ext_active;
  } ipcd_state_type;

  ipcd_state_type st_r;
  ipcd_state_type st_nxt;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_COUNT - 1);

  ipcd_if det_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // pins seen by the block; the small package bonds out pin 2 only
  logic [5:0] pins;
  logic       setup_phase;
  logic       access_done;
  logic       wr_ok;
  logic       rd_change;
  logic [7:0] rd_byte;
  logic [3:0] enabled_flags;

  assign pins = PIN28 ? (i_input_pin & PIN28_MASK) : i_input_pin; // R17

  // change detection covers pins 0 to 3 only
  assign det_bus.tick  = st_r.tick;
  assign det_bus.level = pins[3:0]; // R10

  ipcd_detect u_detect (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .bus       (det_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus phase decode
  // access phase waits one cycle so that read data comes from a flop
  assign setup_phase = i_psel && i_penable && !st_r.pready;
  assign access_done = i_psel && i_penable && st_r.pready;
  assign wr_ok       = access_done && i_pwrite && !st_r.pslverr;
  assign rd_change   = access_done && !i_pwrite && (i_paddr == OFS_CHANGE);

  ////////////////////////////////////////////////////////////////////////////
  // read data mux
  always_comb
  begin
    rd_byte = 8'h00;
    case (i_paddr)
      OFS_PIN_STATE : rd_byte = {2'h0, pins};                       // R1 R2
      OFS_CHANGE    : rd_byte = {st_r.change_flags, pins[3:0]};     // R12
      OFS_AUX       : rd_byte = st_r.auxiliary_control;
      OFS_IMASK     : rd_byte = st_r.interrupt_mask;
      OFS_MODE2_A   : rd_byte = st_r.mode_two_chan_a;
      OFS_MODE2_B   : rd_byte = st_r.mode_two_chan_b;
      OFS_CLKSEL_A  : rd_byte = st_r.clock_select_chan_a;
      OFS_CLKSEL_B  : rd_byte = st_r.clock_select_chan_b;
      default       : rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    st_nxt = st_r;

    // sample tick divider, stands in for the bit rate generator output
    if (st_r.tick_cnt == TICK_LAST)
    begin
      st_nxt.tick_cnt = '0;
      st_nxt.tick     = 1'b1; // R10
    end
    else
    begin
      st_nxt.tick_cnt = st_r.tick_cnt + 1'b1;
      st_nxt.tick     = 1'b0;
    end

    // apb answer: pready rises one cycle into the access phase
    if (setup_phase)
    begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = !addr_mapped(i_paddr);
      st_nxt.prdata  = i_pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end
    else
    begin
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
    end

    // writes land on the edge where the master samples pready
    if (wr_ok)
    begin
      case (i_paddr)
        OFS_AUX      : st_nxt.auxiliary_control   = i_pwdata[7:0]; // R16
        OFS_IMASK    : st_nxt.interrupt_mask      = i_pwdata[7:0];
        OFS_MODE2_A  : st_nxt.mode_two_chan_a     = i_pwdata[7:0];
        OFS_MODE2_B  : st_nxt.mode_two_chan_b     = i_pwdata[7:0];
        OFS_CLKSEL_A : st_nxt.clock_select_chan_a = i_pwdata[7:0];
        OFS_CLKSEL_B : st_nxt.clock_select_chan_b = i_pwdata[7:0];
        default      : st_nxt.change_flags        = st_r.change_flags;
      endcase
    end

    // read clears only the flags it reported, so a change that lands while
    // the read is in flight is kept; a change in the clear cycle still sets
    if (rd_change)
      st_nxt.change_flags = st_nxt.change_flags & ~st_r.prdata[7:4]; // R13
    st_nxt.change_flags = st_nxt.change_flags | det_bus.change; // R12

    // per-pin enables gate the flags before the global mask
    enabled_flags = st_nxt.change_flags & st_nxt.auxiliary_control[3:0]; // R14

    // two-tier enable onto the single interrupt line
    st_nxt.irq = st_nxt.interrupt_mask[IMASK_CHANGE_BIT] && (|enabled_flags); // R15

    // alternate function routing, idle values when not selected
    st_nxt.cts_a_n = st_r.mode_two_chan_a[MODE2_CTS_BIT] ? pins[0] : 1'b1; // R3
    st_nxt.cts_b_n = st_r.mode_two_chan_b[MODE2_CTS_BIT] ? pins[1] : 1'b1; // R4

    st_nxt.timer_clk = (st_r.auxiliary_control[6:4] == CT_EXT_CODE) ? pins[2] : 1'b0; // R5

    st_nxt.ext_active[0] = ext_clock_sel(st_r.clock_select_chan_b[7:4]); // R6
    st_nxt.ext_active[1] = ext_clock_sel(st_r.clock_select_chan_a[3:0]); // R7
    st_nxt.ext_active[2] = ext_clock_sel(st_r.clock_select_chan_a[7:4]); // R8
    st_nxt.ext_active[3] = ext_clock_sel(st_r.clock_select_chan_b[3:0]); // R9

    st_nxt.rxc_b = st_nxt.ext_active[0] ? pins[2] : 1'b0; // R6
    st_nxt.txc_a = st_nxt.ext_active[1] ? pins[3] : 1'b0; // R7
    st_nxt.rxc_a = st_nxt.ext_active[2] ? pins[4] : 1'b0; // R8
    st_nxt.txc_b = st_nxt.ext_active[3] ? pins[5] : 1'b0; // R9
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, constants only under reset
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_r                     <= '0;
      st_r.auxiliary_control   <= REG_RESET;
      st_r.interrupt_mask      <= REG_RESET;
      st_r.mode_two_chan_a     <= REG_RESET;
      st_r.mode_two_chan_b     <= REG_RESET;
      st_r.clock_select_chan_a <= REG_RESET;
      st_r.clock_select_chan_b <= REG_RESET;
      st_r.cts_a_n             <= 1'b1;
      st_r.cts_b_n             <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register
  assign o_prdata                 = st_r.prdata;
  assign o_pready                 = st_r.pready;
  assign o_pslverr                = st_r.pslverr;
  assign o_irq                    = st_r.irq;
  assign o_clear_to_send_chan_a_n = st_r.cts_a_n;
  assign o_clear_to_send_chan_b_n = st_r.cts_b_n;
  assign o_timer_ext_clock_in     = st_r.timer_clk;
  assign o_rx_clock_in_chan_b     = st_r.rxc_b;
  assign o_tx_clock_in_chan_a     = st_r.txc_a;
  assign o_rx_clock_in_chan_a     = st_r.rxc_a;
  assign o_tx_clock_in_chan_b     = st_r.txc_b;
  assign o_timer_mode             = st_r.auxiliary_control[6:4]; // R16
  assign o_brg_set2               = st_r.auxiliary_control[AUX_BRG_BIT]; // R16
  assign o_ext_clock_active       = st_r.ext_active;

endmodule

// ---- verification/ipcd_monitor.sv ----
/*
  ipcd_monitor: port checker for ipcd_top, bound at the foot.
  Assumes APB and pins change only just after a rising edge.
*/
`timescale 1ns/1ns
module ipcd_monitor
#(
  parameter bit PIN28 = 1'b0
)
(
  input wire logic        i_mclk,
  input wire logic        i_reset_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [5:0]  i_input_pin,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_clear_to_send_chan_a_n,
  input wire logic        o_clear_to_send_chan_b_n,
  input wire logic        o_timer_ext_clock_in,
  input wire logic        o_rx_clock_in_chan_b,
  input wire logic        o_tx_clock_in_chan_a,
  input wire logic        o_rx_clock_in_chan_a,
  input wire logic        o_tx_clock_in_chan_b,
  input wire logic [2:0]  o_timer_mode,
  input wire logic [3:0]  o_ext_clock_active
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // pins unchanged for three edges, so any input register has caught up
  logic [5:0] pin_q;
  logic [1:0] calm_r;
  // pins as the block sees them; the small package bonds out pin 2 only
  wire  [5:0] pin_seen = PIN28 ? (i_input_pin & 6'h04) : i_input_pin;
  wire        rd_ok = i_psel & i_penable & o_pready & ~i_pwrite & (calm_r == 2'h3);

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pin_q  <= '0;
      calm_r <= '0;
    end
    else
    begin
      pin_q  <= i_input_pin;
      calm_r <= (i_input_pin != pin_q) ? 2'h0 : ((calm_r == 2'h3) ? 2'h3 : calm_r + 2'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_PIN_READ: assert property (rd_ok && i_paddr == 12'h000 |->
    o_prdata == {26'h0, pin_seen}) else $error("pin state read wrong");
  AST_CHG_LEVEL: assert property (rd_ok && i_paddr == 12'h004 |->
    o_prdata[3:0] == pin_seen[3:0] && o_prdata[31:8] == 24'h0)
    else $error("change status levels wrong");
  AST_CTS_A: assert property (!o_clear_to_send_chan_a_n |->
    !$past(pin_seen[0])) else $error("cts a low with pin high");
  AST_CTS_B: assert property (!o_clear_to_send_chan_b_n |->
    !$past(pin_seen[1])) else $error("cts b low with pin high");
  AST_TIMER_CLK: assert property (o_timer_mode == 3'h0 && $past(o_timer_mode) == 3'h0 |->
    o_timer_ext_clock_in == $past(pin_seen[2])) else $error("timer clock not pin 2");
  AST_RXB: assert property (o_ext_clock_active[0] && $past(o_ext_clock_active[0], 2) |->
    o_rx_clock_in_chan_b == $past(pin_seen[2])) else $error("rx b clock not pin 2");
  AST_TXA: assert property (o_ext_clock_active[1] && $past(o_ext_clock_active[1], 2) |->
    o_tx_clock_in_chan_a == $past(pin_seen[3])) else $error("tx a clock not pin 3");
  AST_RXA: assert property (o_ext_clock_active[2] && $past(o_ext_clock_active[2], 2) |->
    o_rx_clock_in_chan_a == $past(pin_seen[4])) else $error("rx a clock not pin 4");
  AST_TXB: assert property (o_ext_clock_active[3] && $past(o_ext_clock_active[3], 2) |->
    o_tx_clock_in_chan_b == $past(pin_seen[5])) else $error("tx b clock not pin 5");
  // one access cycle of wait, then a single ready pulse
  AST_READY: assert property (i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
    else $error("ready not a pulse in second access cycle");
  AST_ERR: assert property (o_pslverr |-> o_pready) else $error("error without ready");
endmodule

bind ipcd_top ipcd_monitor #(.PIN28(PIN28)) u_mon (.*);

// ---- verification/ipcd_pin_src.sv ----
/*
  ipcd_pin_src: external modem and clock sources on the six input pins.
  Assumes the bench sets i_want just after a rising edge.
*/
`timescale 1ns/1ns
module ipcd_pin_src
(
  input  wire logic       i_mclk,
  input  wire logic       i_lag,
  input  wire logic [5:0] i_want,
  output logic      [5:0] o_pin = 6'h00
);
  logic [5:0] hold_r = 6'h00;

  // slow source adds a cycle, edges stay the same distance apart
  always @(posedge i_mclk)
  begin
    hold_r <= i_want;
    o_pin  <= i_lag ? hold_r : i_want;
  end
endmodule

// ---- verification/ipcd_top_tb.sv ----
/*
  ipcd_top_tb: self-checking bench for ipcd_top with a short sample tick.
  Assumes the pin source model and the bound port checker.
*/
`timescale 1ns/1ns
module ipcd_top_tb
  import ipcd_pkg::*;
;
  localparam int TK = 8;
  logic i_mclk = 0, i_reset_n = 0, psel = 0, pen = 0, pwr = 0, lag = 0, er;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd, rd, prd28, rd28;
  logic [5:0] want = 0, pins;
  logic rdy, err, irq, cta, ctb, tex, rxb, txa, rxa, txb, bit_rate_generator;
  logic [2:0] tmode;
  logic [3:0] eca;
  int fails = 0, tests_run = 0, cyc = 0;

  ipcd_top #(.PIN28(1'b0), .TICK_COUNT(TK)) i_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
    .o_prdata(prd), .o_pready(rdy), .o_pslverr(err), .i_input_pin(pins), .o_irq(irq),
    .o_clear_to_send_chan_a_n(cta), .o_clear_to_send_chan_b_n(ctb),
    .o_timer_ext_clock_in(tex), .o_rx_clock_in_chan_b(rxb), .o_tx_clock_in_chan_a(txa),
    .o_rx_clock_in_chan_a(rxa), .o_tx_clock_in_chan_b(txb), .o_timer_mode(tmode),
    .o_brg_set2(bit_rate_generator), .o_ext_clock_active(eca));
  // small package build on the same bus and pins; the bench checks only its read data, the bound port checker checks its ports too
  ipcd_top #(.PIN28(1'b1), .TICK_COUNT(TK)) i_dut28 (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
    .o_prdata(prd28), .o_pready(), .o_pslverr(), .i_input_pin(pins), .o_irq(),
    .o_clear_to_send_chan_a_n(), .o_clear_to_send_chan_b_n(),
    .o_timer_ext_clock_in(), .o_rx_clock_in_chan_b(), .o_tx_clock_in_chan_a(),
    .o_rx_clock_in_chan_a(), .o_tx_clock_in_chan_b(), .o_timer_mode(),
    .o_brg_set2(), .o_ext_clock_active());
  ipcd_pin_src i_src (.i_mclk(i_mclk), .i_lag(lag), .i_want(want), .o_pin(pins));

  always #5 i_mclk = ~i_mclk;

  // hang guard, about fifty times the expected run
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      $display("BAD %0t timeout", $time);
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  // request stands until ready is seen at a rising edge; the design updates
  // by nonblocking assignment, so right after the edge we read its old values
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
    @(posedge i_mclk);
    pen <= 1;
    do
    begin
      @(posedge i_mclk);
    end
    while (rdy !== 1'b1);
    rd   = prd;
    rd28 = prd28;
    er   = err;
    psel <= 0; pen <= 0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int a = 8; a <= 28; a += 4)
    begin
      apb(0, a[11:0], 0);
      chk(rd, 0);
      apb(1, a[11:0], 32'hFFFF_FF00 | a);
      apb(0, a[11:0], 0);
      chk(rd, a);
      apb(1, a[11:0], 0);
    end
    apb(0, 12'h020, 0);
    chk({31'h0, er}, 1);
    chk(rd, 0);
  endtask

  task automatic t_pins();
    logic [5:0] p [4] = '{6'h15, 6'h2A, 6'h3F, 6'h00};
    foreach (p[i])
    begin
      want <= p[i];
      settle(4);
      apb(0, OFS_PIN_STATE, 0);
      chk(rd, {26'h0, p[i]});
      chk(rd28, {26'h0, p[i] & PIN28_MASK});
    end
  endtask

  task automatic t_route();
    logic [3:0] c [3] = '{4'hE, 4'hF, 4'hD};
    logic [5:0] p;
    logic on;
    apb(1, OFS_MODE2_A, 8'h10);
    apb(1, OFS_MODE2_B, 8'h10);
    foreach (c[i])
    begin
      on = (c[i] != 4'hD);
      apb(1, OFS_CLKSEL_A, {c[i], c[i]});
      apb(1, OFS_CLKSEL_B, {c[i], c[i]});
      for (int k = 0; k < 3; k++)
      begin
        p = (k == 1) ? 6'h3F : 6'h2A >> k;
        want <= p;
        settle(4);
        chk({cta, ctb, tex, rxb, txa, rxa, txb}, {p[0], p[1], p[2], {4{on}} & {p[2], p[3], p[4], p[5]}});
        chk(eca, {4{on}});
      end
    end
    apb(1, OFS_MODE2_A, 0);
    apb(1, OFS_AUX, 8'hC0);
    settle(3);
    chk({cta, tex, bit_rate_generator, tmode}, 6'h2C);
    apb(1, OFS_AUX, 0);
    want <= 0;
    settle(4 * TK);
  endtask

  task automatic t_change();
    apb(1, OFS_AUX, 8'h01);
    apb(1, OFS_IMASK, 8'h80);
    apb(0, OFS_CHANGE, 0);
    want <= 6'h32;
    settle(4 * TK);
    chk(irq, 0);
    apb(0, OFS_CHANGE, 0);
    chk(rd, 8'h22);
    apb(0, OFS_CHANGE, 0);
    chk(rd, 8'h02);
    apb(1, OFS_IMASK, 0);
    want <= 6'h33;
    settle(4 * TK);
    chk(irq, 0);
    apb(1, OFS_IMASK, 8'h80);
    settle(3);
    chk(irq, 1);
    apb(0, OFS_CHANGE, 0);
    chk(rd, 8'h13);
    settle(3);
    chk(irq, 0);
    lag <= 1;
    want <= 6'h3B;
    settle(2 * TK + 2);
    want <= 6'h33;
    settle(3);
    apb(0, OFS_CHANGE, 0);
    chk(rd, 8'h83);
    settle(3 * TK);
    apb(0, OFS_CHANGE, 0);
    chk(rd, 8'h83);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    settle(3);
    i_reset_n <= 1;
    t_regs();
    t_pins();
    t_route();
    t_change();
    final_report();
  end
endmodule
